// [include/hfp_pkg.sv]
package hfp_pkg;
   // register addresses
   localparam logic [7:0] HFP_RX_PORT_ADDR = 8'hB4;
   localparam logic [7:0] HFP_TX_STATUS_ADDR = 8'hB6;
   localparam logic [7:0] HFP_TX_PORT_ADDR = 8'hB7;
   localparam logic [7:0] HFP_ROUTING_ADDR = 8'hB8;
   // field positions
   localparam int HFP_SRC_BIT = 7;
   localparam int HFP_SACH_BIT = 6;
   localparam int HFP_MODE_BIT = 5;
   localparam int HFP_UDR_BIT = 0;
   localparam int HFP_FULL_BIT = 1;
   localparam int HFP_EMPTY_BIT = 2;
   // reset value, count constant and fifo depth
   localparam logic [7:0] HFP_ROUTING_RST = 8'h00;
   localparam logic [4:0] HFP_COUNT_ONE = 5'h01;
   localparam int HFP_FIFO_DEPTH = 16;

   // receive byte with its message markers
   typedef struct packed {
      logic opening;
      logic closing;
      logic valid_last;
      logic [7:0] data;
   } hfp_rx_word_t;

   // host port access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hfp_host_req_t;

   // routing decode result
   typedef struct packed {
      logic use_sa;
      logic [4:0] sa_mask;
      logic single_ch;
      logic [4:0] ch_num;
      logic multi_ch;
   } hfp_route_t;
endpackage

// [rtl/hfp_fifo.sv]
`timescale 1ns/1ps
module hfp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // status
   output logic full,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign full = (cnt_q == (AW+1)'(DEPTH));
   assign empty = (cnt_q == '0);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_q[rp_q];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// [rtl/hfp_ports.sv]
`timescale 1ns/1ps
module hfp_ports
   import hfp_pkg::*;
#(
   parameter int DEPTH = HFP_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host parallel port
   input wire hfp_host_req_t host_req,
   output logic [7:0] host_rdata,
   // receive packet engine side
   input wire logic rx_in_valid,
   output logic rx_in_ready,
   input wire hfp_rx_word_t rx_in_word,
   // transmit packet engine side
   output logic tx_out_valid,
   input wire logic tx_out_ready,
   output logic [7:0] tx_out_data,
   input wire logic tx_in_packet,
   output logic tx_abort,
   // e1 timeslot framing
   input wire logic [4:0] rx_ts_num,
   input wire logic rx_ts_is_sa,
   input wire logic [4:0] rx_sa_from_ctrl_two,
   input wire logic [31:0] rx_channel_block_mask,
   output logic rx_take_bits,
   output logic [4:0] rx_sa_enable,
   // receive status
   output logic rx_fifo_empty_flag,
   output logic opening_byte_flag,
   output logic closing_byte_flag,
   output logic valid_message_last_byte_flag
);
   logic [7:0] rx_packet_routing_control_q;
   logic tx_fifo_underrun_flag_q;
   logic tx_abort_q;
   logic [7:0] host_rdata_q;
   logic tx_fifo_empty_flag, tx_fifo_full_flag;
   logic rx_valid;
   hfp_rx_word_t rx_head;
   hfp_route_t route;

   wire rd_rx_port = host_req.rd && (host_req.addr == HFP_RX_PORT_ADDR);
   wire rd_tx_status = host_req.rd && (host_req.addr == HFP_TX_STATUS_ADDR);
   wire wr_tx_port = host_req.wr && (host_req.addr == HFP_TX_PORT_ADDR);
   wire wr_routing = host_req.wr && (host_req.addr == HFP_ROUTING_ADDR);
   wire rd_routing = host_req.rd && (host_req.addr == HFP_ROUTING_ADDR);

   hfp_fifo #(.WIDTH(11), .DEPTH(DEPTH)) u_rx_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(rx_in_valid),
      .in_ready(rx_in_ready),
      .in_data(rx_in_word),
      .out_valid(rx_valid),
      .out_ready(rd_rx_port),
      .out_data(rx_head),
      .full(),
      .empty(rx_fifo_empty_flag)
   );

   hfp_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(wr_tx_port),
      .in_ready(),
      .in_data(host_req.wdata),
      .out_valid(tx_out_valid),
      .out_ready(tx_out_ready),
      .out_data(tx_out_data),
      .full(tx_fifo_full_flag),
      .empty(tx_fifo_empty_flag)
   );

   // live head-of-fifo markers, gated by data present
   assign opening_byte_flag = rx_valid && rx_head.opening;
   assign closing_byte_flag = rx_valid && rx_head.closing;
   assign valid_message_last_byte_flag = rx_valid && rx_head.valid_last;

   // routing decode
   function automatic hfp_route_t decode_route(input logic [7:0] c);
      hfp_route_t r;
      r = '0;
      if (!c[HFP_SRC_BIT]) begin
         r.use_sa = 1'b1;
      end else if (!c[HFP_SACH_BIT]) begin
         r.use_sa = 1'b1;
         r.sa_mask = c[4:0];
      end else if (!c[HFP_MODE_BIT]) begin
         r.single_ch = 1'b1;
         r.ch_num = c[4:0];
      end else begin
         r.multi_ch = 1'b1;
      end
      return r;
   endfunction

   assign route = decode_route(rx_packet_routing_control_q);
   // source 0 takes sa set from control two, source 1 takes routing sa bits when bit 6 is clear, else zero
   assign rx_sa_enable = !rx_packet_routing_control_q[HFP_SRC_BIT]
      ? rx_sa_from_ctrl_two : route.sa_mask;
   wire single_hit = route.single_ch && (rx_ts_num == route.ch_num);
   wire multi_hit = route.multi_ch && rx_channel_block_mask[rx_ts_num];
   assign rx_take_bits = route.use_sa ? rx_ts_is_sa : (single_hit || multi_hit);

   // underrun: fifo dry while a packet is being sent
   wire underrun_ev = tx_in_packet && tx_fifo_empty_flag && tx_out_ready;
   assign tx_abort = tx_abort_q;

   // register read mux, unassigned status bits read as zero
   wire [7:0] tx_status = {5'h00, tx_fifo_empty_flag, tx_fifo_full_flag,
      tx_fifo_underrun_flag_q};
   wire [7:0] rd_mux = rd_rx_port ? rx_head.data :
      rd_tx_status ? tx_status :
      rd_routing ? rx_packet_routing_control_q : 8'h00;
   assign host_rdata = host_rdata_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_packet_routing_control_q <= HFP_ROUTING_RST;
         tx_fifo_underrun_flag_q <= 1'b0;
         tx_abort_q <= 1'b0;
         host_rdata_q <= 8'h00;
      end else begin
         if (wr_routing) begin
            rx_packet_routing_control_q <= host_req.wdata;
         end
         // set wins over read clear
         if (underrun_ev) begin
            tx_fifo_underrun_flag_q <= 1'b1;
         end else if (rd_tx_status) begin
            tx_fifo_underrun_flag_q <= 1'b0;
         end
         tx_abort_q <= underrun_ev;
         if (host_req.rd) begin
            host_rdata_q <= rd_mux;
         end
      end
   end

   udr_set_a: assert property (@(posedge clk) disable iff (rst)
      underrun_ev |=> tx_fifo_underrun_flag_q && tx_abort)
      else $error("underrun did not latch or abort");
   udr_hold_a: assert property (@(posedge clk) disable iff (rst)
      tx_fifo_underrun_flag_q && !rd_tx_status |=> tx_fifo_underrun_flag_q)
      else $error("underrun flag dropped without read");
   udr_clear_a: assert property (@(posedge clk) disable iff (rst)
      rd_tx_status && !underrun_ev |=> !tx_fifo_underrun_flag_q)
      else $error("underrun flag not cleared by read");
   tx_empty_a: assert property (@(posedge clk) disable iff (rst)
      wr_tx_port && !tx_out_ready |=> !tx_fifo_empty_flag)
      else $error("tx empty after write");
   tx_full_a: assert property (@(posedge clk) disable iff (rst)
      tx_fifo_full_flag |-> !tx_fifo_empty_flag)
      else $error("tx full and empty together");
   rx_read_a: assert property (@(posedge clk) disable iff (rst)
      rd_rx_port |=> host_rdata == $past(rx_head.data))
      else $error("rx port data mismatch");
   rx_flags_a: assert property (@(posedge clk) disable iff (rst)
      rx_fifo_empty_flag |-> !opening_byte_flag && !closing_byte_flag
      && !valid_message_last_byte_flag)
      else $error("marker flags set on empty fifo");
   single_ch_a: assert property (@(posedge clk) disable iff (rst)
      route.single_ch && rx_ts_num != rx_packet_routing_control_q[4:0]
      |-> !rx_take_bits)
      else $error("wrong channel taken");
   status_pad_a: assert property (@(posedge clk) disable iff (rst)
      rd_tx_status |=> host_rdata[7:3] == 5'h00)
      else $error("unassigned status bits nonzero");
endmodule

// [verif/hfp_host_model.sv]
`timescale 1ns/1ps
module hfp_host_model
   import hfp_pkg::*;
(
   // clock
   input wire logic clk,
   // host port
   output hfp_host_req_t host_req,
   input wire logic [7:0] host_rdata
);
   initial begin
      host_req = '0;
   end
   // one-cycle write strobe, bit 7 of the byte is its msb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge clk);
      host_req.wr = 1'b0;
   endtask
   // read strobe, answer taken once the registered data settles
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge clk);
      host_req.rd = 1'b0;
      @(negedge clk);
      d = host_rdata;
   endtask
endmodule

// [verif/hdlc_fifo_ports_and_rx_routing_tb_top.sv]
`timescale 1ns/1ps
module hdlc_fifo_ports_and_rx_routing_tb_top
   import hfp_pkg::*;
;
   logic clk, rst, rx_in_valid, rx_in_ready, tx_out_valid, tx_out_ready, tx_in_packet;
   logic tx_abort, rx_ts_is_sa, rx_take_bits, rx_empty, f_open, f_close, f_ok;
   logic [7:0] host_rdata, tx_out_data, b, st;
   logic [4:0] rx_ts_num, rx_sa_ctl, rx_sa_enable;
   logic [31:0] rx_mask;
   hfp_host_req_t host_req;
   hfp_rx_word_t rx_in_word, w;
   int err_count, n_tests, cyc, i, r;
   int txq[$];
   hfp_rx_word_t rxq[$];
   hfp_ports #(.DEPTH(HFP_FIFO_DEPTH)) dut (.clk(clk), .rst(rst), .host_req(host_req),
      .host_rdata(host_rdata), .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
      .rx_in_word(rx_in_word), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
      .tx_out_data(tx_out_data), .tx_in_packet(tx_in_packet), .tx_abort(tx_abort),
      .rx_ts_num(rx_ts_num), .rx_ts_is_sa(rx_ts_is_sa), .rx_sa_from_ctrl_two(rx_sa_ctl),
      .rx_channel_block_mask(rx_mask), .rx_take_bits(rx_take_bits),
      .rx_sa_enable(rx_sa_enable), .rx_fifo_empty_flag(rx_empty), .opening_byte_flag(f_open),
      .closing_byte_flag(f_close), .valid_message_last_byte_flag(f_ok));
   hfp_host_model host (.clk(clk), .host_req(host_req), .host_rdata(host_rdata));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         summarize();
      end
   end
   initial begin
      {rst, rx_in_valid, tx_out_ready, tx_in_packet, rx_ts_is_sa} = 5'h10;
      {rx_in_word, rx_ts_num, rx_sa_ctl, rx_mask} = '0;
      void'($urandom(32'hBFAF));
      repeat (8) @(negedge clk);
      rst = 1'b0;
      host.rd(HFP_ROUTING_ADDR, b);
      chk(b, HFP_ROUTING_RST, "route rst");
      host.rd(HFP_TX_STATUS_ADDR, st);
      chk(st & 8'h07, 8'h04, "stat rst");
      host.rd(8'hB5, b);
      chk(b, 8'h00, "unmapped");
      // fill past full, the extra byte is dropped
      for (i = 0; i < 17; i++) begin
         b = 8'($urandom);
         host.wr(HFP_TX_PORT_ADDR, b);
         if (i < HFP_FIFO_DEPTH) txq.push_back(b);
      end
      host.rd(HFP_TX_STATUS_ADDR, st);
      chk(st & 8'h07, 8'h02, "full");
      tx_out_ready = 1'b1;
      while (txq.size() > 0) begin
         chk(8'(tx_out_valid), 8'h01, "tx valid");
         chk(tx_out_data, 8'(txq.pop_front()), "tx byte");
         @(negedge clk);
      end
      tx_out_ready = 1'b0;
      chk(8'(tx_out_valid), 8'h00, "tx idle");
      host.rd(HFP_TX_STATUS_ADDR, st);
      chk(st & 8'h07, 8'h04, "drained");
      // dry fifo mid-packet
      tx_in_packet = 1'b1;
      tx_out_ready = 1'b1;
      @(negedge clk);
      tx_in_packet = 1'b0;
      tx_out_ready = 1'b0;
      chk(8'(tx_abort), 8'h01, "abort");
      @(negedge clk);
      chk(8'(tx_abort), 8'h00, "abort end");
      host.rd(HFP_TX_STATUS_ADDR, st);
      chk(st & 8'h07, 8'h05, "udr set");
      host.rd(HFP_TX_STATUS_ADDR, st);
      chk(st & 8'h07, 8'h04, "udr clr");
      rx_in_valid = 1'b1;
      for (i = 0; i < HFP_FIFO_DEPTH; i++) begin
         w = hfp_rx_word_t'(11'($urandom));
         rx_in_word = w;
         rxq.push_back(w);
         chk(8'(rx_in_ready), 8'h01, "rx ready");
         @(negedge clk);
      end
      rx_in_valid = 1'b0;
      chk(8'(rx_in_ready), 8'h00, "rx full");
      while (rxq.size() > 0) begin
         w = rxq.pop_front();
         chk(8'({f_open, f_close, f_ok}), 8'({w.opening, w.closing, w.valid_last}), "fl");
         chk(8'(rx_empty), 8'h00, "rx busy");
         host.rd(HFP_RX_PORT_ADDR, b);
         chk(b, w.data, "rx byte");
      end
      chk(8'(rx_empty), 8'h01, "rx empty");
      for (i = 0; i < 40; i++) begin
         r = $urandom;
         b = 8'(r);
         b[7:5] = {i % 4 != 0, i % 4 > 1, i % 4 == 3};
         host.wr(HFP_ROUTING_ADDR, b);
         rx_ts_num = r[20] ? b[4:0] : 5'(r >> 8);
         rx_ts_is_sa = r[16];
         rx_sa_ctl = 5'(r >> 24);
         rx_mask = $urandom;
         @(negedge clk);
         if (!b[7] || !b[6]) begin
            chk(8'(rx_take_bits), 8'(rx_ts_is_sa), "sa take");
            chk(8'(rx_sa_enable), 8'(b[7] ? b[4:0] : rx_sa_ctl), "sa en");
         end else begin
            r = b[5] ? rx_mask[rx_ts_num] : rx_ts_num == b[4:0];
            chk(8'(rx_take_bits), 8'(r), "ds0 take");
         end
         host.rd(HFP_ROUTING_ADDR, st);
         chk(st, b, "route rd");
      end
      summarize();
   end
endmodule
